// file: core/dhrs_params.svh
// Purpose: timing constants for the display hardware reset sequencer
// Assumes: 100 MHz core clock
// Notes: counts are derived from the printed times
`ifndef DHRS_PARAMS_SVH
`define DHRS_PARAMS_SVH
`define DHRS_CLK_MHZ 100
`define DHRS_REJECT_NS 5000
`define DHRS_FULL_NS 9000
`define DHRS_REL_SLEEP_US 5000
`define DHRS_REL_AWAKE_US 120000
`define DHRS_WAKE_WAIT_US 120000
// least time rounds up; 5 us filter must reject anything shorter
`define DHRS_REJECT_CYC ((`DHRS_REJECT_NS * `DHRS_CLK_MHZ + 999) / 1000)
// longest time rounds down; a full reset is taken by 9 us
`define DHRS_FULL_CYC ((`DHRS_FULL_NS * `DHRS_CLK_MHZ) / 1000)
`define DHRS_REL_SLEEP_CYC (`DHRS_REL_SLEEP_US * `DHRS_CLK_MHZ)
`define DHRS_REL_AWAKE_CYC (`DHRS_REL_AWAKE_US * `DHRS_CLK_MHZ)
`define DHRS_WAKE_WAIT_CYC (`DHRS_WAKE_WAIT_US * `DHRS_CLK_MHZ)
`define DHRS_CNT_W 24
`define DHRS_FLT_W 11
// pin flops ahead of the filter; their delay counts into the release interval
`define DHRS_SYNC_LAT 2
`endif

// file: core/dhrs_pkg.sv
// Purpose: types for the display hardware reset sequencer
// Assumes: one-hot state codes
// Notes: none
package dhrs_pkg;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_BLANK = 5'h02,
      ST_HELD = 5'h04,
      ST_LOAD = 5'h08,
      ST_SETTLE = 5'h10
   } dhrs_state_t;
endpackage : dhrs_pkg

// file: core/dhrs_seq.sv
// Purpose: qualify the host reset pin, blank, reload settings, gate commands
// Assumes: hw_reset_n is asynchronous; nvm loader answers with nvm_done
// Notes: long counts are parameters so simulation can shorten them
// Summary of operation
// [R1] low pulses under 5 us are ignored and pulses over 9 us give a full reset.
// [R2] high spikes inside a valid reset are filtered the same way and do not end it.
// [R3] on release the id bytes, common voltage setting and settings are reloaded.
// [R4] a reset taken while awake blanks the display in at most 120 ms.
// [R5] a reset taken while asleep keeps the display blank and restores defaults.
// [R6] the release interval ends within 5 ms after a reset taken asleep.
// [R7] the release interval may last up to 120 ms after a reset taken awake.
// [R8] the host waits 5 ms after release before sending any command.
// [R9] the host waits 120 ms after release before the wake command.
// [R10] commands during the release interval are rejected and busy shows until loaded.
`timescale 1ns/1ps
`include "dhrs_params.svh"
module dhrs_seq #(
   parameter int FLT_CYC = `DHRS_REJECT_CYC,
   parameter int REL_SLEEP_CYC = `DHRS_REL_SLEEP_CYC,
   parameter int REL_AWAKE_CYC = `DHRS_REL_AWAKE_CYC,
   parameter int BLANK_MAX_CYC = `DHRS_REL_AWAKE_CYC,
   parameter int WAKE_WAIT_CYC = `DHRS_WAKE_WAIT_CYC
) (
   // clock and core reset
   input wire logic clock,
   input wire logic nrst,
   // host reset pin
   input wire logic hw_reset_n,
   // display state
   input wire logic sleep_out,
   input wire logic blank_done,
   // settings loader
   output logic nvm_load,
   input wire logic nvm_done,
   // outputs to the core
   output logic blank_req,
   output logic core_reset,
   output logic busy,
   // command gate
   input wire logic cmd_valid,
   input wire logic cmd_is_wake,
   output logic cmd_accept,
   output logic cmd_reject
);
   localparam int CW = `DHRS_CNT_W;
   localparam int FW = `DHRS_FLT_W;

   logic sync1_ff, sync2_ff;
   logic filt_ff;
   logic [FW-1:0] flt_cnt_ff;
   logic asleep_ff;
   logic [CW-1:0] rel_cnt_ff;
   logic [CW-1:0] wake_cnt_ff;
   logic load_done_ff;
   dhrs_pkg::dhrs_state_t state_ff, nxt_state;

   // two flops; only the second is read
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= hw_reset_n;
         sync2_ff <= sync1_ff;
      end
   end

   // symmetric filter: a change must persist FLT_CYC cycles to be taken, so
   // short lows are rejected and short highs during reset do not end it
   always_ff @(posedge clock) begin
      if (!nrst) begin
         filt_ff <= 1'b1;
         flt_cnt_ff <= '0;
      end else if (sync2_ff == filt_ff) begin
         flt_cnt_ff <= '0; // R1 R2
      end else if (flt_cnt_ff == FW'(FLT_CYC - 1)) begin
         filt_ff <= sync2_ff; // R1 R2
         flt_cnt_ff <= '0;
      end else begin
         flt_cnt_ff <= flt_cnt_ff + 1'b1;
      end
   end

   wire rst_seen = !filt_ff;

   // sleep mode captured when the qualified reset begins
   always_ff @(posedge clock) begin
      if (!nrst) begin
         asleep_ff <= 1'b1;
      end else if (state_ff == dhrs_pkg::ST_RUN && rst_seen) begin
         asleep_ff <= !sleep_out; // R5
      end
   end

   // sequence control
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         dhrs_pkg::ST_RUN: begin
            if (rst_seen) begin
               nxt_state = asleep_ff_next() ? dhrs_pkg::ST_HELD : dhrs_pkg::ST_BLANK;
            end
         end
         dhrs_pkg::ST_BLANK: begin
            // blanking ends on done or at the 120 ms bound
            if (blank_done || rel_cnt_ff >= CW'(BLANK_MAX_CYC - 1)) begin
               nxt_state = dhrs_pkg::ST_HELD; // R4
            end
         end
         dhrs_pkg::ST_HELD: begin
            if (!rst_seen) begin
               nxt_state = dhrs_pkg::ST_LOAD; // R3
            end
         end
         dhrs_pkg::ST_LOAD: begin
            if (rst_seen) begin
               nxt_state = dhrs_pkg::ST_HELD;
            end else if (nvm_done) begin
               nxt_state = dhrs_pkg::ST_SETTLE;
            end
         end
         dhrs_pkg::ST_SETTLE: begin
            if (rst_seen) begin
               nxt_state = dhrs_pkg::ST_HELD;
            end else if (rel_cnt_ff >= CW'((asleep_ff ? REL_SLEEP_CYC : REL_AWAKE_CYC) - 1)) begin
               nxt_state = dhrs_pkg::ST_RUN; // R6 R7
            end
         end
         default: nxt_state = dhrs_pkg::ST_RUN;
      endcase
   end

   function automatic logic asleep_ff_next();
      asleep_ff_next = !sleep_out;
   endfunction : asleep_ff_next

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_ff <= dhrs_pkg::ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // interval counter: counts blanking, then the release interval from release
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rel_cnt_ff <= '0;
      end else if (state_ff == dhrs_pkg::ST_HELD && nxt_state == dhrs_pkg::ST_LOAD) begin
         // the pin rose sync plus filter cycles ago; the interval is timed from the pin
         rel_cnt_ff <= CW'(FLT_CYC + `DHRS_SYNC_LAT); // R6 R7
      end else if (state_ff != nxt_state && nxt_state != dhrs_pkg::ST_SETTLE) begin
         rel_cnt_ff <= '0;
      end else if (state_ff == dhrs_pkg::ST_HELD || state_ff == dhrs_pkg::ST_RUN) begin
         rel_cnt_ff <= '0;
      end else if (rel_cnt_ff != '1) begin
         rel_cnt_ff <= rel_cnt_ff + 1'b1;
      end
   end

   // wake command guard counts from release of reset
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wake_cnt_ff <= '0;
      end else if (rst_seen) begin
         wake_cnt_ff <= '0;
      end else if (wake_cnt_ff < CW'(WAKE_WAIT_CYC)) begin
         wake_cnt_ff <= wake_cnt_ff + 1'b1; // R9
      end
   end

   // settings loaded flag, cleared by every reset
   always_ff @(posedge clock) begin
      if (!nrst) begin
         load_done_ff <= 1'b0;
      end else if (rst_seen) begin
         load_done_ff <= 1'b0;
      end else if (state_ff == dhrs_pkg::ST_LOAD && nvm_done) begin
         load_done_ff <= 1'b1; // R3
      end
   end

   // load strobe is a level held while loading; loader finishes with nvm_done
   assign nvm_load = (state_ff == dhrs_pkg::ST_LOAD); // R3
   assign blank_req = (state_ff != dhrs_pkg::ST_RUN); // R4 R5
   assign core_reset = (state_ff == dhrs_pkg::ST_HELD) || (state_ff == dhrs_pkg::ST_BLANK);
   assign busy = !load_done_ff; // R10
   // early or too-early wake commands are refused instead of corrupting the load
   wire gate_open = (state_ff == dhrs_pkg::ST_RUN) &&
                    !(cmd_is_wake && wake_cnt_ff < CW'(WAKE_WAIT_CYC));
   assign cmd_accept = cmd_valid && gate_open; // R8 R10
   assign cmd_reject = cmd_valid && !gate_open; // R10

   // checker helpers: lengths of the synced low and high runs, saturating
   int flt_low_cnt;
   always_ff @(posedge clock) begin
      if (!nrst || sync2_ff) begin
         flt_low_cnt <= 0;
      end else if (flt_low_cnt < FLT_CYC) begin
         flt_low_cnt <= flt_low_cnt + 1;
      end
   end

   int flt_high_cnt;
   always_ff @(posedge clock) begin
      if (!nrst || !sync2_ff) begin
         flt_high_cnt <= 0;
      end else if (flt_high_cnt < FLT_CYC) begin
         flt_high_cnt <= flt_high_cnt + 1;
      end
   end

   property p_short_low; // R1
      @(posedge clock) disable iff (!nrst)
      (filt_ff && flt_low_cnt < FLT_CYC - 1) |=> filt_ff;
   endproperty
   a_short_low: assert property (p_short_low) else $error("short low taken"); // R1

   property p_long_low; // R1
      @(posedge clock) disable iff (!nrst)
      (!sync2_ff && flt_low_cnt == FLT_CYC - 1) |=> !filt_ff;
   endproperty
   a_long_low: assert property (p_long_low) else $error("long low missed"); // R1

   property p_spike_hold; // R2
      @(posedge clock) disable iff (!nrst)
      (!filt_ff && flt_high_cnt < FLT_CYC - 1) |=> !filt_ff;
   endproperty
   a_spike_hold: assert property (p_spike_hold) else $error("spike ended reset"); // R2

   sequence s_release;
      state_ff == dhrs_pkg::ST_HELD && !rst_seen;
   endsequence
   property p_load_after; // R3
      @(posedge clock) disable iff (!nrst)
      s_release |=> nvm_load;
   endproperty
   a_load_after: assert property (p_load_after) else $error("no load on release"); // R3

   property p_blank; // R4
      @(posedge clock) disable iff (!nrst)
      state_ff == dhrs_pkg::ST_BLANK |-> blank_req && rel_cnt_ff < CW'(BLANK_MAX_CYC);
   endproperty
   a_blank: assert property (p_blank) else $error("blank too long"); // R4

   property p_sleep_hold; // R5
      @(posedge clock) disable iff (!nrst)
      (state_ff == dhrs_pkg::ST_RUN && rst_seen && !sleep_out) |=> state_ff == dhrs_pkg::ST_HELD;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep reset blanked"); // R5

   property p_rel_bound; // R6 R7
      @(posedge clock) disable iff (!nrst)
      state_ff == dhrs_pkg::ST_SETTLE |->
         rel_cnt_ff < CW'(asleep_ff ? REL_SLEEP_CYC : REL_AWAKE_CYC);
   endproperty
   a_rel_bound: assert property (p_rel_bound) else $error("release too long"); // R6 R7

   property p_reject; // R10
      @(posedge clock) disable iff (!nrst)
      (cmd_valid && state_ff != dhrs_pkg::ST_RUN) |-> cmd_reject && !cmd_accept;
   endproperty
   a_reject: assert property (p_reject) else $error("command during release"); // R10
endmodule : dhrs_seq

// file: verif/dhrs_host.sv
// Purpose: host model that drives the reset pin and offers commands
// Assumes: a command is judged in the cycle it is offered
// Notes: the bench may skip the host waits on purpose to see refusals
`timescale 1ns/1ps
module dhrs_host (
   // clock
   input wire logic clock,
   // reset pin
   output logic hw_reset_n,
   // command offer
   output logic cmd_valid,
   output logic cmd_is_wake,
   input wire logic cmd_accept,
   input wire logic cmd_reject
);
   // pin idles high with no command offered
   initial begin
      hw_reset_n = 1'b1;
      cmd_valid = 1'b0;
      cmd_is_wake = 1'b0;
   end
   // low, then an optional high spike and a second low; hi of 0 gives one pulse
   task automatic pulse(input int lo, input int hi, input int lo2);
      hw_reset_n <= 1'b0;
      repeat (lo) @(posedge clock);
      if (hi > 0) begin
         hw_reset_n <= 1'b1;
         repeat (hi) @(posedge clock);
         hw_reset_n <= 1'b0;
         repeat (lo2) @(posedge clock);
      end
      hw_reset_n <= 1'b1;
   endtask : pulse
   // one command held a cycle; the caller decides when the waits are kept
   task automatic cmd(input logic wake, output logic acc, output logic rej);
      cmd_valid <= 1'b1;
      cmd_is_wake <= wake;
      @(posedge clock);
      acc = cmd_accept;
      rej = cmd_reject;
      cmd_valid <= 1'b0;
      @(posedge clock);
   endtask : cmd
endmodule : dhrs_host

// file: verif/dhrs_seq_tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: release counts shortened to 600 and 900 cycles, timed from pin release
// Notes: blank_done is held high so blanking ends at once, except in the spike case
`timescale 1ns/1ps
module dhrs_seq_tb_top;
   logic clock = 1'b0, nrst = 1'b0, hw_reset_n, sleep_out = 1'b0, blank_done = 1'b0;
   logic nvm_done = 1'b0, cmd_valid, cmd_is_wake, nvm_load, blank_req, core_reset;
   logic busy, cmd_accept, cmd_reject, a, r, bad;
   int err_total = 0, checked = 0, cyc = 0;
   // pulse widths in cycles, sleep state and whether a reset is expected
   int lo_cyc[4] = '{490, 510, 950, 1000};
   logic awake_row[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   logic taken_row[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
   dhrs_seq #(.REL_SLEEP_CYC(600), .REL_AWAKE_CYC(900), .BLANK_MAX_CYC(300),
      .WAKE_WAIT_CYC(400)) uut (.clock(clock), .nrst(nrst), .hw_reset_n(hw_reset_n),
      .sleep_out(sleep_out), .blank_done(blank_done), .nvm_load(nvm_load),
      .nvm_done(nvm_done), .blank_req(blank_req), .core_reset(core_reset), .busy(busy),
      .cmd_valid(cmd_valid), .cmd_is_wake(cmd_is_wake), .cmd_accept(cmd_accept),
      .cmd_reject(cmd_reject));
   dhrs_host host (.clock(clock), .hw_reset_n(hw_reset_n), .cmd_valid(cmd_valid),
      .cmd_is_wake(cmd_is_wake), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject));
   // 100 MHz clock
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic print_verdict();
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   // runs from pin release to the open gate; n counts cycles since the release
   task automatic finish_reset(input logic awake);
      int n;
      int rel;
      rel = awake ? 900 : 600;
      chk(blank_req === 1'b1 && core_reset === 1'b1, "not blanked");
      n = 0;
      while (nvm_load !== 1'b1 && n < 700) begin
         @(posedge clock);
         n++;
      end
      chk(nvm_load === 1'b1 && busy === 1'b1, "no settings load");
      host.cmd(1'b0, a, r);
      chk(a === 1'b0 && r === 1'b1, "cmd taken while loading");
      nvm_done <= 1'b1;
      @(posedge clock);
      nvm_done <= 1'b0;
      @(posedge clock);
      chk(busy === 1'b0 && blank_req === 1'b1, "busy after load");
      n += 4;
      while (blank_req === 1'b1 && n < 1500) begin
         @(posedge clock);
         n++;
      end
      chk(n >= rel - 3 && n <= rel + 3, "release interval length");
      chk(core_reset === 1'b0 && nvm_load === 1'b0, "not back to default");
      host.cmd(1'b0, a, r);
      chk(a === 1'b1 && r === 1'b0, "cmd refused after interval");
      // after a sleep reset the wake guard outlives the short interval
      if (!awake) begin
         host.cmd(1'b1, a, r);
         chk(a === 1'b0 && r === 1'b1, "early wake taken");
         repeat (350) @(posedge clock);
         host.cmd(1'b1, a, r);
         chk(a === 1'b1, "late wake refused");
      end
   endtask : finish_reset
   // hang guard well above the longest expected run
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      chk(busy === 1'b1 && blank_req === 1'b0 && core_reset === 1'b0, "reset values");
      nrst <= 1'b1;
      blank_done <= 1'b1;
      @(posedge clock);
      host.cmd(1'b1, a, r);
      chk(a === 1'b0 && r === 1'b1, "wake taken after reset");
      host.cmd(1'b0, a, r);
      chk(a === 1'b1, "cmd refused after reset");
      for (int i = 0; i < 4; i++) begin
         sleep_out <= awake_row[i];
         host.pulse(lo_cyc[i], 0, 0);
         if (taken_row[i]) finish_reset(awake_row[i]);
         else begin
            bad = 1'b0;
            repeat (700) begin
               @(posedge clock);
               if (blank_req !== 1'b0) bad = 1'b1;
            end
            chk(!bad, "short pulse taken");
         end
      end
      // high spike inside a valid reset must not release it
      bad = 1'b0;
      sleep_out <= 1'b1;
      // blanking left to run to its bound inside the long low
      blank_done <= 1'b0;
      fork
         host.pulse(1000, 100, 600);
         repeat (1699) begin
            @(posedge clock);
            if (nvm_load !== 1'b0) bad = 1'b1;
         end
      join
      chk(!bad, "spike ended reset");
      finish_reset(1'b1);
      print_verdict();
   end
endmodule : dhrs_seq_tb_top
